// *** hdl/tfc_comp_unit.sv ***
// thermometer control and pulse-based frequency compensation top level
`timescale 1ns/10ps
module tfc_comp_unit (
   input  wire logic       clk_sys_in,
   input  wire logic       resetn_in,
   // crystal reference and sensor pins
   input  wire logic       xtal_ref_in,
   input  wire logic [7:0] sensor_code_in,
   input  wire logic       low_voltage_first_flag_in,
   // register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // compensated time base
   output logic            comp_tick_out,
   output logic            sec_tick_out,
   output logic            period_start_out,
   output logic            measure_done_out
);

   // =========================================================================
   // registers
   logic [7:0] temperature_reading_r;
   logic [7:0] thermo_clkout_control_r;
   logic [7:0] crystal_offset_trim_r;
   logic [7:0] crystal_drift_coef_r;
   logic [5:0] turnover_temp_value_r;

   logic       thermo_en;
   logic       scan_interval_select;
   assign thermo_en =
      thermo_clkout_control_r[tfc_pkg::THERMO_EN_BIT];
   assign scan_interval_select =
      thermo_clkout_control_r[tfc_pkg::SCAN_SEL_BIT];

   // =========================================================================
   // pin synchronisers
   logic       xtal_sync;
   logic [7:0] sensor_sync;
   logic       low_voltage_first_flag;

   tfc_sync #(
      .W (1)
   ) u_sync_xtal (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .d_in       (xtal_ref_in),
      .q_out      (xtal_sync)
   );

   tfc_sync #(
      .W (8)
   ) u_sync_sensor (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .d_in       (sensor_code_in),
      .q_out      (sensor_sync)
   );

   tfc_sync #(
      .W (1)
   ) u_sync_lv (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .d_in       (low_voltage_first_flag_in),
      .q_out      (low_voltage_first_flag)
   );

   // a multi-bit code can tear in the synchroniser; only a code seen
   // on two edges in a row is taken as settled
   logic [7:0] sensor_prev_r;
   logic [7:0] sensor_stable_r;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sensor_prev_r <= '0;
      end else begin
         sensor_prev_r <= sensor_sync;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sensor_stable_r <= tfc_pkg::RST_TEMP_READING;
      end else if (sensor_sync == sensor_prev_r) begin
         sensor_stable_r <= sensor_prev_r;
      end
   end

   // =========================================================================
   // reference edge detect
   logic xtal_prev_r;
   logic ref_tick;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xtal_prev_r <= 1'b0;
      end else begin
         xtal_prev_r <= xtal_sync;
      end
   end

   assign ref_tick = xtal_sync & ~xtal_prev_r;

   // =========================================================================
   // correction calculation
   logic signed [tfc_pkg::CORR_W-1:0] corr_calc;
   logic signed [tfc_pkg::CORR_W-1:0] corr_active_r;
   logic        [11:0]                corr_mag;
   logic                              corr_add;

   tfc_corr_calc u_calc (
      .clk_sys_in  (clk_sys_in),
      .resetn_in   (resetn_in),
      .temp_in     (temperature_reading_r),
      .turnover_in (turnover_temp_value_r),
      .coef_in     (crystal_drift_coef_r),
      .offset_in   (crystal_offset_trim_r),
      .corr_out    (corr_calc)
   );

   assign corr_add = ~corr_active_r[tfc_pkg::CORR_W-1];
   assign corr_mag = corr_active_r[tfc_pkg::CORR_W-1]
                   ? 12'(-corr_active_r)
                   : corr_active_r[11:0];

   // =========================================================================
   // seconds divider and 32-second period counter
   logic [14:0] div_cnt_r;
   logic [4:0]  period_cnt_r;
   logic        comp_tick;
   logic        sec_wrap;
   logic        period_wrap;

   assign sec_wrap    = comp_tick && (div_cnt_r == tfc_pkg::REF_DIV_LAST);
   assign period_wrap = sec_wrap && (period_cnt_r == tfc_pkg::PERIOD_LAST);

   // compensated pulses clock the first divider stage
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_cnt_r <= '0;
      end else if (comp_tick) begin
         div_cnt_r <= sec_wrap ? '0 : div_cnt_r + 15'h0001;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         period_cnt_r <= '0;
      end else if (sec_wrap) begin
         period_cnt_r <= period_wrap ? '0 : period_cnt_r + 5'h01;
      end
   end

   // new value taken at each period boundary only
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         corr_active_r <= '0;
      end else if (period_wrap) begin
         corr_active_r <= corr_calc;
      end
   end

   // =========================================================================
   // pulse distribution over the period
   // accumulator adds the count at every reference edge; with 2^20 edges
   // per period exactly the count of carries appears, evenly spaced
   logic [tfc_pkg::PERIOD_REF_LOG2-1:0] acc_r;
   logic [tfc_pkg::PERIOD_REF_LOG2:0]   acc_sum;
   logic                                corr_due;

   assign acc_sum  = {1'b0, acc_r} + {9'h000, corr_mag};
   assign corr_due = ref_tick && acc_sum[tfc_pkg::PERIOD_REF_LOG2];

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_r <= '0;
      end else if (period_wrap) begin
         acc_r <= '0;
      end else if (ref_tick) begin
         acc_r <= acc_sum[tfc_pkg::PERIOD_REF_LOG2-1:0];
      end
   end

   // =========================================================================
   // pulse insertion and removal
   // an inserted pulse follows the reference edge after a short gap,
   // well inside one reference period
   logic [2:0] ins_cnt_r;
   logic       ins_fire;

   assign ins_fire = (ins_cnt_r == 3'h1);

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ins_cnt_r <= '0;
      end else if (corr_due && corr_add) begin
         ins_cnt_r <= tfc_pkg::INSERT_GAP_CYC;
      end else if (ins_cnt_r != 3'h0) begin
         ins_cnt_r <= ins_cnt_r - 3'h1;
      end
   end

   // removal swallows the reference edge itself
   assign comp_tick = (ref_tick && !(corr_due && !corr_add)) || ins_fire;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         comp_tick_out    <= 1'b0;
         sec_tick_out     <= 1'b0;
         period_start_out <= 1'b0;
      end else begin
         comp_tick_out    <= comp_tick;
         sec_tick_out     <= sec_wrap;
         period_start_out <= period_wrap;
      end
   end

   // =========================================================================
   // thermometer scan scheduling
   logic [3:0] scan_cnt_r;
   logic       scan_due;
   logic       measure;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scan_cnt_r <= '0;
      end else if (sec_wrap) begin
         scan_cnt_r <= (scan_cnt_r == tfc_pkg::SLOW_SCAN_LAST)
                     ? '0 : scan_cnt_r + 4'h1;
      end
   end

   assign scan_due = sec_wrap
                  && (!scan_interval_select
                      || scan_cnt_r == tfc_pkg::SLOW_SCAN_LAST);
   assign measure  = scan_due && thermo_en
                  && !low_voltage_first_flag;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         measure_done_out <= 1'b0;
      end else begin
         measure_done_out <= measure;
      end
   end

   // =========================================================================
   // register writes
   logic wr_temp;
   assign wr_temp = reg_wr_in && (reg_addr_in == tfc_pkg::ADDR_TEMP_READING);

   // sensor code already counts C+60 in one-degree steps
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         temperature_reading_r <= tfc_pkg::RST_TEMP_READING;
      end else if (measure) begin
         temperature_reading_r <= sensor_stable_r;
      end else if (wr_temp && !thermo_en) begin
         temperature_reading_r <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         thermo_clkout_control_r <= tfc_pkg::RST_THERMO_CTRL;
         crystal_offset_trim_r   <= tfc_pkg::RST_XTAL_OFFSET;
         crystal_drift_coef_r    <= tfc_pkg::RST_XTAL_COEF;
         turnover_temp_value_r   <= tfc_pkg::RST_TURNOVER_TEMP;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            tfc_pkg::ADDR_THERMO_CTRL: begin
               thermo_clkout_control_r <= reg_wdata_in;
            end
            tfc_pkg::ADDR_XTAL_OFFSET: begin
               crystal_offset_trim_r <= reg_wdata_in;
            end
            tfc_pkg::ADDR_XTAL_COEF: begin
               crystal_drift_coef_r <= reg_wdata_in;
            end
            tfc_pkg::ADDR_TURNOVER_TEMP: begin
               turnover_temp_value_r <=
                  reg_wdata_in[tfc_pkg::TURNOVER_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // =========================================================================
   // register reads, data one cycle after the strobe
   logic [7:0] rd_mux;
   logic [15:0] corr_ext;

   // readback shows the value computed now, loaded at the next boundary
   assign corr_ext = 16'(corr_calc);

   always_comb begin
      unique case (reg_addr_in)
         tfc_pkg::ADDR_TEMP_READING:  rd_mux = temperature_reading_r;
         tfc_pkg::ADDR_THERMO_CTRL:   rd_mux = thermo_clkout_control_r;
         tfc_pkg::ADDR_XTAL_OFFSET:   rd_mux = crystal_offset_trim_r;
         tfc_pkg::ADDR_XTAL_COEF:     rd_mux = crystal_drift_coef_r;
         tfc_pkg::ADDR_TURNOVER_TEMP: rd_mux = {2'b00, turnover_temp_value_r};
         tfc_pkg::ADDR_CORR_LOW:      rd_mux = corr_ext[7:0];
         tfc_pkg::ADDR_CORR_HIGH:     rd_mux = corr_ext[15:8];
         default:                     rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_mux;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

endmodule // tfc_comp_unit

// *** hdl/tfc_pkg.sv ***
// constants and register map of the temperature frequency compensation block
package tfc_pkg;

   // =========================================================================
   // register offsets
   localparam logic [7:0] ADDR_TEMP_READING  = 8'h20;
   localparam logic [7:0] ADDR_THERMO_CTRL   = 8'h30;
   localparam logic [7:0] ADDR_XTAL_OFFSET   = 8'h31;
   localparam logic [7:0] ADDR_XTAL_COEF     = 8'h32;
   localparam logic [7:0] ADDR_TURNOVER_TEMP = 8'h33;
   localparam logic [7:0] ADDR_CORR_LOW      = 8'h34;
   localparam logic [7:0] ADDR_CORR_HIGH     = 8'h35;

   // =========================================================================
   // field positions
   localparam int THERMO_EN_BIT   = 1;
   localparam int SCAN_SEL_BIT    = 0;
   localparam int OFFSET_SIGN_BIT = 7;
   localparam int OFFSET_MAG_W    = 7;
   localparam int TURNOVER_W      = 6;
   localparam int CORR_W          = 13;

   // =========================================================================
   // reset values
   localparam logic [7:0] RST_TEMP_READING  = 8'h3C;
   localparam logic [7:0] RST_THERMO_CTRL   = 8'h02;
   localparam logic [7:0] RST_XTAL_OFFSET   = 8'h00;
   localparam logic [7:0] RST_XTAL_COEF     = 8'h00;
   localparam logic [5:0] RST_TURNOVER_TEMP = 6'h15;

   // =========================================================================
   // temperature scaling
   localparam logic [9:0] TEMP_ZERO_CODE     = 10'h03C;
   localparam logic [9:0] TURNOVER_BIAS      = 10'h004;
   localparam logic [23:0] DRIFT_ROUND       = 24'h000800;
   localparam int          DRIFT_SHIFT       = 12;

   // =========================================================================
   // timing
   localparam int          REF_HZ            = 32768;
   localparam int          CLK_HZ            = 100_000_000;
   localparam logic [14:0] REF_DIV_LAST      = 15'(REF_HZ - 1);
   localparam int          PERIOD_SECONDS    = 32;
   localparam logic [4:0]  PERIOD_LAST       = 5'(PERIOD_SECONDS - 1);
   localparam int          SLOW_SCAN_SECONDS = 16;
   localparam logic [3:0]  SLOW_SCAN_LAST    = 4'(SLOW_SCAN_SECONDS - 1);
   localparam int          PERIOD_REF_LOG2   = 20;
   localparam int          INSERT_GAP_NS     = 40;
   localparam int          CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
   localparam logic [2:0]  INSERT_GAP_CYC    =
      3'((INSERT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : tfc_pkg

// *** hdl/tfc_sync.sv ***
// two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/10ps
module tfc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_in,
   input  wire logic         resetn_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end

endmodule // tfc_sync

// *** hdl/tfc_corr_calc.sv ***
// signed per-period pulse count from crystal parameters and temperature
`timescale 1ns/10ps
module tfc_corr_calc (
   input  wire logic                        clk_sys_in,
   input  wire logic                        resetn_in,
   input  wire logic [7:0]                  temp_in,
   input  wire logic [5:0]                  turnover_in,
   input  wire logic [7:0]                  coef_in,
   input  wire logic [7:0]                  offset_in,
   output logic signed [tfc_pkg::CORR_W-1:0] corr_out
);

   // =========================================================================
   // quadratic drift term
   logic signed [9:0]  dt;
   logic        [7:0]  dt_mag;
   logic        [15:0] dt_sq;
   logic        [23:0] drift_prod;
   logic        [23:0] drift_round;
   logic        [11:0] drift;
   logic signed [tfc_pkg::CORR_W-1:0] off_term;
   logic signed [tfc_pkg::CORR_W-1:0] drift_term;

   // reading codes C+60, turnover field codes C-4
   assign dt = $signed({2'b00, temp_in})
             - $signed({4'b0000, turnover_in})
             - $signed(tfc_pkg::TEMP_ZERO_CODE)
             - $signed(tfc_pkg::TURNOVER_BIAS);
   assign dt_mag      = dt[9] ? 8'(-dt) : dt[7:0];
   assign dt_sq       = dt_mag * dt_mag;
   assign drift_prod  = dt_sq * coef_in;
   assign drift_round = drift_prod + tfc_pkg::DRIFT_ROUND;
   assign drift       = drift_round[tfc_pkg::DRIFT_SHIFT +: 12];
   assign drift_term  = $signed({1'b0, drift});
   assign off_term    = $signed({6'h00,
                           offset_in[tfc_pkg::OFFSET_MAG_W-1:0]});

   // =========================================================================
   // positive result adds pulses; a fast crystal needs pulses removed
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         corr_out <= '0;
      end else if (offset_in[tfc_pkg::OFFSET_SIGN_BIT]) begin
         corr_out <= drift_term - off_term;
      end else begin
         corr_out <= drift_term + off_term;
      end
   end

endmodule // tfc_corr_calc

// *** sim/tfc_comp_props.sv ***
// assertion checker for the compensation block ports
`timescale 1ns/10ps
module tfc_comp_props (
   input wire logic       clk_sys_in,
   input wire logic       resetn_in,
   input wire logic       xtal_ref_in,
   input wire logic       low_voltage_first_flag_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       comp_tick_out,
   input wire logic       sec_tick_out,
   input wire logic       period_start_out,
   input wire logic       measure_done_out
);
   // =====================================================================
   // shadow of the control register and of recent reference edges
   logic [7:0] ctrl_r;
   logic [9:0] rise_r;
   logic       xtal_r;

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_r <= tfc_pkg::RST_THERMO_CTRL;
      end else if (reg_wr_in && reg_addr_in == 8'h30) begin
         ctrl_r <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xtal_r <= 1'b0;
         rise_r <= 10'h000;
      end else begin
         xtal_r <= xtal_ref_in;
         rise_r <= {rise_r[8:0], xtal_ref_in & ~xtal_r};
      end
   end

   // =====================================================================
   // properties
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);

   sequence s_wr_temp;
      reg_wr_in && reg_addr_in == 8'h20 && !ctrl_r[1];
   endsequence
   sequence s_rd_temp;
      reg_rd_in && reg_addr_in == 8'h20;
   endsequence

   a_rdata_idle_zero: assert property (
      !reg_rd_in |=> reg_rdata_out == 8'h00) else $error("rdata not idle");
   a_ctrl_read_back: assert property (
      reg_rd_in && reg_addr_in == 8'h30 |=> reg_rdata_out == $past(ctrl_r))
      else $error("control readback wrong");
   a_temp_write_kept: assert property (
      s_wr_temp ##2 s_rd_temp |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("temperature write lost");
   a_tick_has_edge: assert property (
      comp_tick_out |-> rise_r != 10'h000) else $error("tick without edge");
   a_tick_single: assert property (
      comp_tick_out |=> !comp_tick_out) else $error("tick too long");
   a_sec_on_tick: assert property (
      sec_tick_out |-> comp_tick_out) else $error("second off tick");
   a_period_on_sec: assert property (
      period_start_out |-> sec_tick_out) else $error("period off second");
   a_done_on_sec: assert property (
      measure_done_out |-> sec_tick_out)
      else $error("measurement off second");
   a_lowv_blocks: assert property (
      low_voltage_first_flag_in [*6] |-> !measure_done_out)
      else $error("measured in low voltage");
endmodule // tfc_comp_props

bind tfc_comp_unit tfc_comp_props i_props (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
   .xtal_ref_in(xtal_ref_in),
   .low_voltage_first_flag_in(low_voltage_first_flag_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .comp_tick_out(comp_tick_out),
   .sec_tick_out(sec_tick_out), .period_start_out(period_start_out),
   .measure_done_out(measure_done_out));

// *** sim/tfc_comp_unit_test.sv ***
// self-checking bench for the compensation block
`timescale 1ns/10ps
module tfc_comp_unit_test;
   logic        clk_sys_in, resetn_in, xtal_ref_in, low_voltage_first_flag_in;
   logic [7:0]  sensor_code_in, reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic        reg_wr_in, reg_rd_in, comp_tick_out, sec_tick_out;
   logic        period_start_out, measure_done_out;
   int          err_count, samples_checked, tick_count, sec_count;
   int          tick_base, done_count, period_count;
   logic [7:0]  lo, hi;
   logic [15:0] e;
   // temperature, turnover, coefficient, offset per case
   logic [7:0]  tv [5] = '{8'h5F, 8'h55, 8'h00, 8'hFA, 8'h64};
   logic [7:0]  t0v [5] = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h3F};
   logic [7:0]  cv [5] = '{8'hFF, 8'h40, 8'h01, 8'hFF, 8'h80};
   logic [7:0]  ov [5] = '{8'h00, 8'h85, 8'h79, 8'hF9, 8'h00};

   tfc_comp_unit i_dut (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .xtal_ref_in(xtal_ref_in), .sensor_code_in(sensor_code_in),
      .low_voltage_first_flag_in(low_voltage_first_flag_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .comp_tick_out(comp_tick_out),
      .sec_tick_out(sec_tick_out), .period_start_out(period_start_out),
      .measure_done_out(measure_done_out));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      if (comp_tick_out === 1'b1) tick_count++;
      if (sec_tick_out === 1'b1) sec_count++;
      if (measure_done_out === 1'b1) done_count++;
      if (period_start_out === 1'b1) period_count++;
   end

   // =====================================================================
   // access tasks
   task automatic check(input string n, input logic [15:0] x,
                        input logic [15:0] g);
      samples_checked++;
      if (g !== x) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask

   task automatic read_check(input string n, input logic [7:0] a,
                             input logic [7:0] x);
      logic [7:0] d;
      reg_read(a, d);
      check(n, {8'h00, x}, {8'h00, d});
   endtask

   // rounded drift plus signed offset, in pulses per period
   function automatic logic [15:0] exp_corr(int t, int t0, int c,
                                            logic [7:0] o);
      int diff, drift, mag;
      diff = t - t0 - 64;
      drift = (c * diff * diff + 2048) / 4096;
      mag = int'(o[6:0]);
      return 16'(o[7] ? drift - mag : drift + mag);
   endfunction

   task automatic do_reset();
      resetn_in <= 1'b0;
      repeat (16) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
   endtask

   task report_and_stop();
      if (err_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys_in);
      err_count++;
      report_and_stop();
   end

   // =====================================================================
   // main sequence
   initial begin
      resetn_in = 1'b0;
      xtal_ref_in = 1'b0;
      sensor_code_in = 8'h4B;
      low_voltage_first_flag_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      err_count = 0;
      samples_checked = 0;
      do_reset();
      read_check("temp_reading", 8'h20, 8'h3C);
      read_check("thermo_ctrl", 8'h30, 8'h02);
      read_check("offset_trim", 8'h31, 8'h00);
      read_check("drift_coef", 8'h32, 8'h00);
      read_check("turnover", 8'h33, 8'h15);
      read_check("unmapped", 8'h7E, 8'h00);
      reg_write(8'h20, 8'hA5);
      read_check("temp_refused", 8'h20, 8'h3C);
      reg_write(8'h30, 8'hFD);
      read_check("thermo_ctrl", 8'h30, 8'hFD);
      for (int i = 0; i < 5; i++) begin
         reg_write(8'h20, tv[i]);
         read_check("temp_written", 8'h20, tv[i]);
         reg_write(8'h33, t0v[i]);
         reg_write(8'h32, cv[i]);
         reg_write(8'h31, ov[i]);
         read_check("offset_trim", 8'h31, ov[i]);
         read_check("drift_coef", 8'h32, cv[i]);
         e = exp_corr(int'(tv[i]), int'(t0v[i]), int'(cv[i]), ov[i]);
         reg_read(8'h34, lo);
         reg_read(8'h35, hi);
         check("correction", e, {hi, lo});
      end
      reg_write(8'h34, 8'h12);
      read_check("corr_read_only", 8'h34, 8'h17);
      // reference edges with no correction latched yet pass one for one
      @(posedge clk_sys_in);
      tick_base = tick_count;
      low_voltage_first_flag_in <= 1'b1;
      repeat (200) begin
         xtal_ref_in <= 1'b1;
         repeat (4) @(posedge clk_sys_in);
         xtal_ref_in <= 1'b0;
         repeat (4) @(posedge clk_sys_in);
      end
      low_voltage_first_flag_in <= 1'b0;
      repeat (10) @(posedge clk_sys_in);
      check("ticks", 16'h00C8, 16'(tick_count - tick_base));
      check("sec_ticks", 16'h0000, 16'(sec_count));
      check("measures", 16'h0000, 16'(done_count));
      check("periods", 16'h0000, 16'(period_count));
      // factory parameter values come back with a reset
      do_reset();
      read_check("offset_trim", 8'h31, 8'h00);
      read_check("temp_reading", 8'h20, 8'h3C);
      report_and_stop();
   end
endmodule // tfc_comp_unit_test
